// file: mopc_ext_mem.sv
// External memory on the non-multiplexed bus, resolving the port 3 pins.
// Assumes page select active low, read/write high for a read.
`timescale 1ns/1ps
`default_nettype none
module mopc_ext_mem
	import mopc_pkg::*;
(
	// Clock and bus phase.
	input wire logic ref_clk,
	input wire logic eClk,
	// Device side of the bus.
	input wire mopc_drive_t port3Drive,
	input wire mopc_drive_t port4Drive,
	input wire logic pageSelN,
	input wire logic readNotWrite,
	// Resolved data pins.
	output logic [7:0] port3In
);
	logic [7:0] memArr [256];
	logic [7:0] lastReg = 8'h00;
	logic [7:0] addrPins;
	logic eReg = 1'b0;
	logic memDrive;
	// Undriven address lines are pulled high.
	assign addrPins = port4Drive.level | ~port4Drive.enable;
	// Drive only while E is high in a selected read, so port 3 never sees two drivers.
	assign memDrive = eClk && !pageSelN && readNotWrite;
	// Nothing pulls port 3, so released bits show the inverse of the last level.
	assign port3In = (port3Drive.level & port3Drive.enable)
		| (~port3Drive.enable & (memDrive ? memArr[addrPins] : ~lastReg));
	initial begin
		for (int i = 0; i < 256; i++) begin
			memArr[i] = 8'(i) ^ 8'h5a;
		end
	end
	// Written data are taken at the falling edge of E.
	always @(posedge ref_clk) begin
		lastReg <= port3In;
		eReg <= eClk;
		if (eReg && !eClk && !pageSelN && !readNotWrite) begin
			memArr[addrPins] <= port3Drive.level;
		end
	end
endmodule
`default_nettype wire

// file: mopc_mode_port.sv
// Operating-mode latch, memory-map decode and port pin configuration.
// Assumes all inputs synchronous to ref_clk, eClk a sampled bus-phase level.
// Contract
// - Eight modes set memory map, ports 3/4, control lines, vector location.
// - Only 18 pins change with mode; the other 22 are mode-independent.
// - Three 8-bit ports and one 5-bit port, 29 lines total.
// - Each port has data and write-only direction registers.
// - Direction clear makes input, set makes output from data register.
// - ROM-less variant supports only modes 2 and 3.
// - Modes 4,7 single-chip, 5 non-multiplexed, others multiplexed.
// - Single-chip: no external bus, all ports I/O plus two handshake lines.
// - Test mode: RAM at XX80-XXFF in every page, ROM removed.
// - Test mode fetches start address from RAM at XXFE/XXFF.
// - Test mode: writing port 2 data bit 5 enters mode 5, irreversible.
// - Mode 5: port 3 is data bus, port 4 starts as inputs.
// - Mode 5: port 4 lines with direction set output A0-A7.
// - Mode 5 maps a 256-byte external window at 100-1FF.
// - Page select asserts whenever address is within 100-1FF.
// - Strap levels latched at reset release, read in port 2 bits 7:5.
// - Mode 5: first control line is page select, second is read/write.
`timescale 1ns/1ps
`default_nettype none
module mopc_mode_port
	import mopc_pkg::*;
#(
	parameter bit ROMLESS_VARIANT = 1'b0
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic reset_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Internal CPU bus and bus-phase clock.
	input wire mopc_cpu_t cpuBus,
	input wire logic eClk,
	// Memory map outputs.
	output logic intRamSelect,
	output logic intRomSelect,
	output logic vectorsExternal,
	output logic vectorFromRam,
	output logic [2:0] currentMode,
	// Port pins.
	input wire logic [7:0] port1In,
	output mopc_drive_t port1Drive,
	input wire logic [4:0] port2In,
	output mopc_drive_t port2Drive,
	input wire logic [7:0] port3In,
	output mopc_drive_t port3Drive,
	input wire logic [7:0] port4In,
	output mopc_drive_t port4Drive,
	// Control lines.
	input wire logic controlLineOneIn,
	output logic controlLineOneOut,
	output logic controlLineOneOe,
	output logic controlLineTwoOut,
	output logic controlLineTwoOe
);
	logic [7:0] p1Dir_reg, p2Dir_reg, p3Dir_reg, p4Dir_reg;
	logic [7:0] p1Data_reg, p3Data_reg, p4Data_reg;
	logic [4:0] p2Data_reg;
	logic [2:0] mode_reg, strapMode;
	logic captured_reg;
	logic dataPhase_reg, dataWrite_reg, readWait_reg;
	logic [3:0] dataIdx_reg;
	logic [31:0] rdata_next;
	logic [1:0] eCount_reg;
	logic ePrev_reg;
	logic writeEn;
	logic singleChip, nonMux, inWindow, extAccess;
	logic [3:0] addrIdx;

	assign addrIdx = haddr[IDX_MSB:IDX_LSB];
	assign writeEn = dataPhase_reg & dataWrite_reg;
	assign hresp = 1'b0;
	// Reads take one wait state so a write just before is already stored.
	assign hreadyout = ~readWait_reg;

	// Address phase capture; a read stalls one cycle in its data phase.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dataPhase_reg <= 1'b0;
			dataWrite_reg <= 1'b0;
			dataIdx_reg <= 4'h0;
			readWait_reg <= 1'b0;
		end else if (hreadyout) begin
			dataPhase_reg <= hsel & htrans[1] & hready;
			dataWrite_reg <= hwrite;
			dataIdx_reg <= addrIdx;
			readWait_reg <= hsel & htrans[1] & hready & ~hwrite;
		end else begin
			readWait_reg <= 1'b0;
		end
	end

	// ROM-less variant keeps only modes 2 and 3, picked by the low strap bit.
	assign strapMode = ROMLESS_VARIANT ? {2'b01, port2In[0]} : port2In[2:0];

	// Mode capture on the first edge after reset release, then held except for the test-mode switch to mode 5.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_reg <= MODE_RESET;
			captured_reg <= 1'b0;
		end else if (!captured_reg) begin
			mode_reg <= strapMode;
			captured_reg <= 1'b1;
		end else if (writeEn && dataIdx_reg == IDX_P2_DATA && mode_reg == MODE_SC_TEST
				&& hwdata[P2_SWITCH_BIT]) begin
			mode_reg <= MODE_NMUX;
		end
		// No other path writes the mode, so it holds until reset.
	end

	// Port registers; direction registers are write-only.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			p1Dir_reg <= DIR_RESET;
			p2Dir_reg <= DIR_RESET;
			p3Dir_reg <= DIR_RESET;
			p4Dir_reg <= DIR_RESET;
			p1Data_reg <= DATA_RESET;
			p2Data_reg <= DATA_RESET[4:0];
			p3Data_reg <= DATA_RESET;
			p4Data_reg <= DATA_RESET;
		end else if (writeEn) begin
			unique case (dataIdx_reg)
				IDX_P1_DIR: p1Dir_reg <= hwdata[7:0];
				IDX_P2_DIR: p2Dir_reg <= {3'h0, hwdata[4:0]};
				IDX_P3_DIR: p3Dir_reg <= hwdata[7:0];
				IDX_P4_DIR: p4Dir_reg <= hwdata[7:0];
				IDX_P1_DATA: p1Data_reg <= hwdata[7:0];
				IDX_P2_DATA: p2Data_reg <= hwdata[4:0];
				IDX_P3_DATA: p3Data_reg <= hwdata[7:0];
				IDX_P4_DATA: p4Data_reg <= hwdata[7:0];
				default: ;
			endcase
		end
	end

	// Read mux on the stalled index: output bits return latch, input bits return the pin.
	always_comb begin
		rdata_next = 32'h0;
		unique case (dataIdx_reg)
			IDX_P1_DATA: rdata_next[7:0] = (p1Dir_reg & p1Data_reg) | (~p1Dir_reg & port1In);
			IDX_P2_DATA: rdata_next[7:0] = {mode_reg, (p2Dir_reg[4:0] & p2Data_reg)
				| (~p2Dir_reg[4:0] & port2In)};
			IDX_P3_DATA: rdata_next[7:0] = (p3Dir_reg & p3Data_reg) | (~p3Dir_reg & port3In);
			IDX_P4_DATA: rdata_next[7:0] = (p4Dir_reg & p4Data_reg) | (~p4Dir_reg & port4In);
			IDX_MODE: rdata_next[2:0] = mode_reg;
			default: rdata_next = 32'h0; // Direction registers and unmapped read zero.
		endcase
	end

	// Read data is registered at the end of the stall, after a preceding write has landed.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			hrdata <= 32'h0;
		end else if (readWait_reg) begin
			hrdata <= rdata_next;
		end
	end

	// Mode 0 vector stays external for two E rising edges after reset.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			eCount_reg <= 2'h0;
			// Starting high means a high E at release is not taken for a rising edge.
			ePrev_reg <= 1'b1;
		end else begin
			ePrev_reg <= eClk;
			if (eClk && !ePrev_reg && eCount_reg != EXT_VEC_E_CYCLES) begin
				eCount_reg <= eCount_reg + 2'h1;
			end
		end
	end

	// Fundamental bus type of the current mode.
	assign singleChip = mode_reg == MODE_SC || mode_reg == MODE_SC_TEST;
	assign nonMux = mode_reg == MODE_NMUX;
	assign inWindow = cpuBus.valid && cpuBus.addr >= WIN_LO && cpuBus.addr <= WIN_HI;
	assign extAccess = nonMux ? inWindow : (!singleChip && cpuBus.valid && !intRamSelect && !intRomSelect);
	assign currentMode = mode_reg;

	// Memory map decode per mode.
	always_comb begin
		intRamSelect = 1'b0;
		intRomSelect = 1'b0;
		vectorsExternal = 1'b0;
		unique case (mode_reg)
			MODE_SC_TEST: begin
				intRamSelect = cpuBus.valid && cpuBus.addr[7];
			end
			MODE_MUX_NONE: begin
				vectorsExternal = 1'b1;
			end
			MODE_MUX_RAM: begin
				intRamSelect = cpuBus.valid && cpuBus.addr >= RAM_LO && cpuBus.addr <= RAM_HI;
				vectorsExternal = 1'b1;
			end
			MODE_MUX_RAM_ROM: begin
				intRamSelect = cpuBus.valid && cpuBus.addr >= RAM_LO && cpuBus.addr <= RAM_HI;
				intRomSelect = cpuBus.valid && cpuBus.addr >= ROM_LO;
				vectorsExternal = 1'b1;
			end
			MODE_MUX_TEST, MODE_NMUX, MODE_MUX_PARTIAL, MODE_SC: begin
				intRamSelect = cpuBus.valid && cpuBus.addr >= RAM_LO && cpuBus.addr <= RAM_HI;
				intRomSelect = cpuBus.valid && cpuBus.addr >= ROM_LO;
				vectorsExternal = mode_reg == MODE_MUX_TEST && eCount_reg != EXT_VEC_E_CYCLES;
			end
		endcase
	end
	// The reset vector at FFFE/FFFF lands in the paged RAM in test mode.
	assign vectorFromRam = mode_reg == MODE_SC_TEST;

	// Ports 1 and 2 are plain I/O in every mode.
	assign port1Drive = '{level: p1Data_reg, enable: p1Dir_reg};
	assign port2Drive = '{level: {3'h0, p2Data_reg}, enable: {3'h0, p2Dir_reg[4:0]}};

	// Port 3, port 4 and control lines follow the mode.
	always_comb begin
		port3Drive = '{level: p3Data_reg, enable: p3Dir_reg};
		port4Drive = '{level: p4Data_reg, enable: p4Dir_reg};
		controlLineOneOut = 1'b1;
		controlLineOneOe = 1'b0; // Input strobe in single-chip.
		controlLineTwoOut = 1'b1;
		controlLineTwoOe = 1'b1;
		if (singleChip) begin
			// Output strobe pulses low on a port 3 data write.
			controlLineTwoOut = ~(writeEn && dataIdx_reg == IDX_P3_DATA);
		end else if (nonMux) begin
			// Device drives data only on its own write while E is high.
			port3Drive = '{level: cpuBus.wdata, enable: {8{extAccess && cpuBus.write && eClk}}};
			port4Drive = '{level: (p4Dir_reg & cpuBus.addr[7:0]) | (~p4Dir_reg & p4Data_reg),
				enable: p4Dir_reg};
			controlLineOneOut = ~inWindow;
			controlLineOneOe = 1'b1;
			controlLineTwoOut = ~(cpuBus.valid && cpuBus.write);
		end else begin
			// Multiplexed: low address while E low, write data while E high.
			port3Drive = '{level: eClk ? cpuBus.wdata : cpuBus.addr[7:0],
				enable: {8{extAccess && (!eClk || cpuBus.write)}}};
			port4Drive = '{level: cpuBus.addr[15:8],
				enable: mode_reg == MODE_MUX_PARTIAL ? p4Dir_reg : 8'hff};
			controlLineOneOut = extAccess && !eClk;
			controlLineOneOe = 1'b1;
			controlLineTwoOut = ~(cpuBus.valid && cpuBus.write);
		end
	end

	// Strobe input and the unused bus bits are tied off here; nothing in this block observes them.
	logic unusedInputs;
	assign unusedInputs = &{controlLineOneIn, hsize, haddr[31:6], haddr[1:0], hwdata[31:8], 1'b0};
endmodule
`default_nettype wire

// file: mopc_mode_port_props.sv
// Checker for the mode latch, address decode and pin roles.
// Assumes it is bound to mopc_mode_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mopc_mode_port_props
	import mopc_pkg::*;
(
	// Clock, reset and bus.
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hreadyout,
	input wire mopc_cpu_t cpuBus,
	// Observed outputs.
	input wire logic [2:0] currentMode,
	input wire logic intRamSelect,
	input wire logic intRomSelect,
	input wire logic vectorFromRam,
	input wire mopc_drive_t port4Drive,
	input wire logic controlLineOneOut,
	input wire logic controlLineOneOe,
	input wire logic controlLineTwoOut
);
	logic swPendReg;
	logic inWin;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Remember a taken port 2 data write so its data phase can be judged.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			swPendReg <= 1'b0;
		end else begin
			swPendReg <= hsel && htrans[1] && hreadyout && hwrite && haddr[5:2] == IDX_P2_DATA;
		end
	end
	// Window decode of the internal bus cycle.
	assign inWin = cpuBus.valid && cpuBus.addr >= WIN_LO && cpuBus.addr <= WIN_HI;
	property p_page_sel;
		currentMode == 3'h5 && cpuBus.valid |-> controlLineOneOut == !inWin && controlLineOneOe;
	endproperty
	a_page_sel: assert property (p_page_sel) else $error("page select wrong");
	property p_rw; currentMode == 3'h5 && cpuBus.valid |-> controlLineTwoOut == !cpuBus.write; endproperty
	a_rw: assert property (p_rw) else $error("read/write line wrong");
	property p_sc_line; currentMode inside {3'h4, 3'h7} |-> !controlLineOneOe; endproperty
	a_sc_line: assert property (p_sc_line) else $error("line one driven in single chip");
	property p_addr_out;
		currentMode == 3'h5 && cpuBus.valid
			|-> (port4Drive.level & port4Drive.enable) == (cpuBus.addr[7:0] & port4Drive.enable);
	endproperty
	a_addr_out: assert property (p_addr_out) else $error("port 4 address wrong");
	property p_test_ram; currentMode == 3'h4 && cpuBus.valid |-> intRamSelect == cpuBus.addr[7] && !intRomSelect; endproperty
	a_test_ram: assert property (p_test_ram) else $error("test mode decode wrong");
	property p_win_ext; currentMode == 3'h5 && inWin |-> !intRamSelect && !intRomSelect; endproperty
	a_win_ext: assert property (p_win_ext) else $error("window decoded inside");
	property p_vec_ram; 1'b1 |-> vectorFromRam == (currentMode == 3'h4); endproperty
	a_vec_ram: assert property (p_vec_ram) else $error("vector source wrong");
	// The strap capture on the first edge after release is a legal change, so two settled cycles are needed.
	property p_mode_hold;
		$past(reset_n, 2) && $past(reset_n) && $past(currentMode) != 3'h4 |-> $stable(currentMode);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode changed");
	property p_mode_four; $past(reset_n) && $past(currentMode) == 3'h4 |-> currentMode inside {3'h4, 3'h5}; endproperty
	a_mode_four: assert property (p_mode_four) else $error("test mode left wrongly");
	property p_switch; swPendReg && hwdata[P2_SWITCH_BIT] && currentMode == 3'h4 |=> currentMode == 3'h5; endproperty
	a_switch: assert property (p_switch) else $error("switch to mode 5 missed");
endmodule
bind mopc_mode_port mopc_mode_port_props u_props (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hwdata,
	.hreadyout, .cpuBus, .currentMode, .intRamSelect, .intRomSelect, .vectorFromRam, .port4Drive,
	.controlLineOneOut, .controlLineOneOe, .controlLineTwoOut);
`default_nettype wire

// file: mopc_mode_port_tb.sv
// Self-checking bench for mopc_mode_port with an external memory.
// Assumes AHB-Lite timing as the design hand-over describes.
`timescale 1ns/1ps
`default_nettype none
module mopc_mode_port_tb
	import mopc_pkg::*;
;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = '0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = '0;
	logic [31:0] hrdata;
	logic hreadyout;
	mopc_cpu_t cpuBus = '0;
	logic eClk = 1'b0;
	logic eDiv = 1'b0;
	logic [7:0] port1In = '0;
	logic [4:0] port2In = '0;
	logic [7:0] port3In;
	logic [7:0] port4In = '0;
	logic controlLineOneIn = 1'b0;
	logic vectorsExternal, vectorFromRam, controlLineOneOut, controlLineTwoOut;
	logic hresp, controlLineTwoOe;
	logic [2:0] currentMode;
	mopc_drive_t port1Drive, port2Drive, port3Drive, port4Drive;
	logic [15:0] cor [4] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200};
	int bad_count = 0;
	int checked = 0;
	int cyc = 0;
	mopc_mode_port dut (.ref_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .cpuBus, .eClk, .intRamSelect(), .intRomSelect(),
		.vectorsExternal, .vectorFromRam, .currentMode, .port1In, .port1Drive, .port2In, .port2Drive,
		.port3In, .port3Drive, .port4In, .port4Drive, .controlLineOneIn, .controlLineOneOut,
		.controlLineOneOe(), .controlLineTwoOut, .controlLineTwoOe);
	mopc_ext_mem u_mem (.ref_clk, .eClk, .port3Drive, .port4Drive, .pageSelN(currentMode != 3'h5 || controlLineOneOut),
		.readNotWrite(controlLineTwoOut), .port3In);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	// E runs at a quarter of the clock; a hang ends the run as a mismatch.
	always @(posedge ref_clk) begin
		eDiv <= ~eDiv;
		if (eDiv) eClk <= ~eClk;
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			report_and_stop();
		end
	end
	function automatic logic vecExt(input logic [2:0] m);
		return m inside {3'h1, 3'h2, 3'h3};
	endfunction
	function automatic logic inWin(input logic [15:0] a);
		return a >= WIN_LO && a <= WIN_HI;
	endfunction
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic ahb(input logic wr, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge ref_clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= wr;
		haddr <= {26'h0, idx, 2'b00};
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge ref_clk);
		while (hreadyout !== 1'b1) @(posedge ref_clk);
		rd = hrdata;
		@(negedge ref_clk);
	endtask
	task automatic doReset(input logic [2:0] strap);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		port2In <= {2'($urandom), strap};
		repeat (8) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		logic [31:0] rd;
		logic [7:0] dir;
		logic [7:0] dat;
		logic [7:0] en;
		void'($urandom(42509));
		port1In <= 8'($urandom);
		port4In <= 8'($urandom);
		controlLineOneIn <= 1'($urandom);
		// Every strap code; a write to the mode register must not stick.
		for (int m = 0; m < 8; m++) begin
			doReset(3'(m));
			// Mode 0 keeps its reset vector outside for the first two E cycles.
			@(negedge ref_clk);
			chk("vectors early", {31'h0, m == 0 || vecExt(3'(m))}, {31'h0, vectorsExternal});
			repeat (8) @(posedge ref_clk);
			ahb(1'b1, IDX_MODE, 32'($urandom), rd);
			ahb(1'b0, IDX_MODE, 32'h0, rd);
			chk("mode reg", 32'(m), rd);
			ahb(1'b0, IDX_P2_DATA, 32'h0, rd);
			chk("p2 mode bits", 32'(m), {29'h0, rd[7:5]});
			chk("vectors ext", {31'h0, vecExt(3'(m))}, {31'h0, vectorsExternal});
		end
		// Port 1 in single chip, write-only direction and an unmapped place.
		dir = 8'($urandom);
		dat = 8'($urandom);
		ahb(1'b1, IDX_P1_DIR, {24'h0, dir}, rd);
		ahb(1'b1, IDX_P1_DATA, {24'h0, dat}, rd);
		ahb(1'b0, IDX_P1_DIR, 32'h0, rd);
		chk("p1 dir read", 32'h0, rd);
		ahb(1'b0, 4'hf, 32'h0, rd);
		chk("unmapped", 32'h0, rd);
		ahb(1'b0, IDX_P1_DATA, 32'h0, rd);
		chk("p1 data", {24'h0, dat & dir | port1In & ~dir}, rd);
		chk("p1 enable", {24'h0, dir}, {24'h0, port1Drive.enable});
		chk("p1 level", {24'h0, dat & dir}, {24'h0, port1Drive.level & dir});
		// Port 2 has five lines; its upper drive bits never enable.
		ahb(1'b1, IDX_P2_DIR, {24'h0, dir}, rd);
		ahb(1'b1, IDX_P2_DATA, {24'h0, dat}, rd);
		chk("p2 enable", {27'h0, dir[4:0]}, {24'h0, port2Drive.enable});
		chk("p2 level", {27'h0, dat[4:0] & dir[4:0]}, {24'h0, port2Drive.level & {3'h0, dir[4:0]}});
		chk("okay resp", 32'h0, {31'h0, hresp});
		// Test mode decode, then the one-way switch to mode 5.
		doReset(3'h4);
		repeat (20) begin
			@(posedge ref_clk);
			cpuBus <= {1'b1, 1'($urandom), 16'($urandom), 8'($urandom)};
		end
		ahb(1'b1, IDX_P2_DATA, 32'h0, rd);
		chk("still test", 32'h4, {29'h0, currentMode});
		ahb(1'b1, IDX_P2_DATA, 32'h20, rd);
		chk("switched", 32'h5, {29'h0, currentMode});
		ahb(1'b1, IDX_P2_DATA, 32'h0, rd);
		chk("no way back", 32'h5, {29'h0, currentMode});
		chk("p4 inputs", 32'h0, {24'h0, port4Drive.enable});
		// Window edges then random addresses with part of port 4 as address.
		dir = 8'($urandom);
		ahb(1'b1, IDX_P4_DIR, {24'h0, dir}, rd);
		for (int i = 0; i < 40; i++) begin
			@(posedge ref_clk);
			cpuBus <= {1'b1, 1'($urandom), (i < 4) ? cor[i] : 16'($urandom) & 16'h03ff, 8'($urandom)};
			@(negedge ref_clk);
			chk("page sel", {31'h0, !inWin(cpuBus.addr)}, {31'h0, controlLineOneOut});
			chk("p4 addr", {24'h0, cpuBus.addr[7:0] & dir}, {24'h0, port4Drive.level & port4Drive.enable});
			chk("p4 enable", {24'h0, dir}, {24'h0, port4Drive.enable});
			chk("rw", {31'h0, !cpuBus.write}, {31'h0, controlLineTwoOut});
			chk("rw oe", 32'h1, {31'h0, controlLineTwoOe});
			// The device drives the data bus only for its own window write while E is high.
			en = {8{inWin(cpuBus.addr) && cpuBus.write && eClk}};
			chk("p3 enable", {24'h0, en}, {24'h0, port3Drive.enable});
			chk("p3 level", {24'h0, cpuBus.wdata & en}, {24'h0, port3Drive.level & en});
		end
		report_and_stop();
	end
endmodule
`default_nettype wire

// file: mopc_pkg.sv
// Package for the operating-mode and port-configuration block.
// Assumes a single 250 MHz clock domain and an AHB-Lite register bus.
package mopc_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [3:0] IDX_P1_DIR = 4'h0;
	localparam logic [3:0] IDX_P2_DIR = 4'h1;
	localparam logic [3:0] IDX_P1_DATA = 4'h2;
	localparam logic [3:0] IDX_P2_DATA = 4'h3;
	localparam logic [3:0] IDX_P3_DIR = 4'h4;
	localparam logic [3:0] IDX_P4_DIR = 4'h5;
	localparam logic [3:0] IDX_P3_DATA = 4'h6;
	localparam logic [3:0] IDX_P4_DATA = 4'h7;
	localparam logic [3:0] IDX_MODE = 4'h8;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 5;
	// Port 2 data register field positions.
	localparam int P2_MODE_LSB = 5;
	localparam int P2_SWITCH_BIT = 5;
	// Widths.
	localparam int PORT_W = 8;
	localparam int PORT5_W = 5;
	// Reset values.
	localparam logic [7:0] DIR_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [2:0] MODE_RESET = 3'h7;
	// Address map constants.
	localparam logic [15:0] WIN_LO = 16'h0100;
	localparam logic [15:0] WIN_HI = 16'h01ff;
	localparam logic [15:0] RAM_LO = 16'h0080;
	localparam logic [15:0] RAM_HI = 16'h00ff;
	localparam logic [15:0] ROM_LO = 16'hf800;
	// E cycles for which mode 0 fetches the reset vector externally.
	localparam logic [1:0] EXT_VEC_E_CYCLES = 2'h2;
	// Operating modes.
	typedef enum logic [2:0] {
		MODE_MUX_TEST = 3'b000,
		MODE_MUX_RAM_ROM = 3'b001,
		MODE_MUX_RAM = 3'b010,
		MODE_MUX_NONE = 3'b011,
		MODE_SC_TEST = 3'b100,
		MODE_NMUX = 3'b101,
		MODE_MUX_PARTIAL = 3'b110,
		MODE_SC = 3'b111
	} mopc_mode_t;
	// One port's pin drive: level and enable per bit.
	typedef struct packed {
		logic [7:0] level;
		logic [7:0] enable;
	} mopc_drive_t;
	// Internal CPU bus cycle as seen by the mode logic.
	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mopc_cpu_t;
endpackage
